// File: design/psf_top.sv
// Panel scaler filter control, coefficient store and pixel stage, two pipes.
// Assumes a simple register port with one-cycle strobes and pixel, blank
// inputs synchronous to clk.
`timescale 1ns/1ps
module psf_top
    import psf_pkg::*;
#(
    parameter int PIX_W = 8
)
(
    // Clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rst,
    // Register port
    input  wire logic [ADDR_W-1:0]                    mmio_addr,
    input  wire logic                                 mmio_wr,
    input  wire logic                                 mmio_rd,
    input  wire logic [31:0]                          mmio_wdata,
    output logic      [31:0]                          mmio_rdata,
    output logic                                      mmio_rvalid,
    // Pipe timing and pixels in
    input  wire logic [PIPES-1:0]                     vblank_start,
    input  wire logic [PIPES-1:0]                     pix_valid,
    input  wire logic [PIPES-1:0][PHASE_W-1:0]        pix_phase,
    input  wire logic [PIPES-1:0][3*PIX_W-1:0]        pix_data,
    // Pixels out
    output logic      [PIPES-1:0]                     out_valid,
    output logic      [PIPES-1:0][3*PIX_W-1:0]        out_data,
    // Coefficient lookup for the filter arithmetic
    input  wire logic [PIPES-1:0][PHASE_W-1:0]        coef_phase,
    input  wire logic [PIPES-1:0][TAP_W-1:0]          coef_tap,
    output logic      [PIPES-1:0][15:0]               coef_value,
    // Active settings
    output logic      [PIPES-1:0]                     scaler_on,
    output logic      [PIPES-1:0]                     adaptive_vertical_on,
    output logic      [PIPES-1:0][1:0]                adaptive_strength,
    output logic      [PIPES-1:0][1:0]                coef_source,
    output logic      [PIPES-1:0]                     chroma_prefilter_on,
    output logic      [PIPES-1:0]                     update_armed
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PIPES-1:0][31:0]                   pend;
        logic [PIPES-1:0][31:0]                   act;
        logic [PIPES-1:0]                         armed;
        logic [PIPES-1:0][COEF_WORDS-1:0][31:0]   coef;
        logic [PIPES-1:0]                         in_vld;
        logic [PIPES-1:0][3*PIX_W-1:0]            in_pix;
        logic [PIPES-1:0][15:0]                   gain;
        logic [PIPES-1:0][2*PIX_W-1:0]            prev_c;
        logic [PIPES-1:0]                         o_vld;
        logic [PIPES-1:0][3*PIX_W-1:0]            o_pix;
        logic [PIPES-1:0][15:0]                   cval;
        logic [31:0]                              rdata;
        logic                                     rvalid;
    } psf_state_s;

    psf_state_s st_r;
    psf_state_s st_nxt;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] base,
                                      input int              words);
        return (a[1:0] == 2'h0) && (a >= base) &&
               ({12'h0, a} < {12'h0, base} + 32'(words * 4));
    endfunction : in_range

    function automatic logic [15:0] coef_half(
        input logic [COEF_WORDS-1:0][31:0] w,
        input logic [HALF_W-1:0]           h);
        logic [31:0] word;
        word = w[h[HALF_W-1:1]];
        return h[0] ? word[31:16] : word[15:0];
    endfunction : coef_half

    function automatic logic [HALF_W-1:0] half_index(input logic [PHASE_W-1:0] ph,
                                                     input logic [TAP_W-1:0]   tp);
        logic [PHASE_W-1:0] p;
        logic [TAP_W-1:0]   t;
        p = (ph >= PHASE_W'(PHASES)) ? PHASE_W'(PHASES - 1) : ph;
        t = (tp >= TAP_W'(TAPS)) ? TAP_W'(TAPS - 1) : tp;
        return HALF_W'(p * TAPS) + HALF_W'(t);
    endfunction : half_index

    // ------------------------------------------------------------------
    // Coefficient decoders, two per pipe
    // ------------------------------------------------------------------
    logic [PIPES-1:0][15:0] center_val;
    logic [PIPES-1:0][15:0] look_val;

    for (genvar g = 0; g < PIPES; g++)
    begin : g_dec
        psf_coef_if cen_if ();
        psf_coef_if look_if ();

        // centre tap of the pixel phase
        assign cen_if.raw     = coef_half(st_r.coef[g],
                                          half_index(pix_phase[g], TAP_W'(CENTER_TAP)));
        assign cen_if.center  = 1'b1;
        assign look_if.raw    = coef_half(st_r.coef[g],
                                          half_index(coef_phase[g], coef_tap[g]));
        assign look_if.center = (coef_tap[g] == TAP_W'(CENTER_TAP));
        assign center_val[g]  = cen_if.value;
        assign look_val[g]    = look_if.value;

        psf_coef_decode u_cen  (.cif(cen_if));
        psf_coef_decode u_look (.cif(look_if));
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    psf_ctrl_s               ctl;
    logic [IDX_W-1:0]        idx;
    logic [PIX_W-1:0]        y;
    logic [PIX_W-1:0]        cb;
    logic [PIX_W-1:0]        cr;
    logic signed [PIX_W+16:0] prod;
    logic [PIX_W:0]          sum_b;
    logic [PIX_W:0]          sum_r;

    always_comb
    begin
        st_nxt = st_r;
        ctl    = psf_unpack(32'h0);
        idx    = '0;
        y      = '0;
        cb     = '0;
        cr     = '0;
        prod   = '0;
        sum_b  = '0;
        sum_r  = '0;
        st_nxt.rvalid = mmio_rd;
        st_nxt.rdata  = '0;
        for (int p = 0; p < PIPES; p++)
        begin
            if (vblank_start[p] && st_r.armed[p])
            begin
                st_nxt.act[p]   = st_r.pend[p];
                st_nxt.armed[p] = 1'b0;
            end
            if (mmio_wr && in_range(mmio_addr, WINSZ_OFS[p], 1))
            begin
                st_nxt.armed[p] = 1'b1;
            end
            if (in_range(mmio_addr, CTRL_OFS[p], 1))
            begin
                if (mmio_wr)
                begin
                    st_nxt.pend[p] = mmio_wdata & CTRL_MASK;
                end
                if (mmio_rd)
                begin
                    st_nxt.rdata = st_r.pend[p];
                end
            end
            if (in_range(mmio_addr, COEF_OFS[p], COEF_WORDS))
            begin
                idx = IDX_W'((mmio_addr - COEF_OFS[p]) >> 2);
                if (mmio_wr)
                begin
                    st_nxt.coef[p][idx] = mmio_wdata & COEF_MASK;
                end
                if (mmio_rd)
                begin
                    st_nxt.rdata = st_r.coef[p][idx];
                end
            end

            st_nxt.cval[p] = look_val[p];

            // Capture stage: pixel and its gain
            ctl = psf_unpack(st_r.act[p]);
            st_nxt.in_vld[p] = pix_valid[p];
            if (pix_valid[p])
            begin
                st_nxt.in_pix[p] = pix_data[p];
                unique case (ctl.src)
                    SRC_PROGRAMMED: st_nxt.gain[p] = center_val[p];
                    SRC_MEDIUM:     st_nxt.gain[p] = GAIN_MEDIUM;
                    SRC_EDGE_ENH:   st_nxt.gain[p] = GAIN_ENH;
                    SRC_EDGE_SOFT:  st_nxt.gain[p] = GAIN_SOFT;
                endcase
            end

            // Output stage
            st_nxt.o_vld[p] = st_r.in_vld[p];
            if (st_r.in_vld[p])
            begin
                {y, cb, cr} = st_r.in_pix[p];
                st_nxt.prev_c[p] = {cb, cr};
                if (!ctl.enable)
                begin
                    st_nxt.o_pix[p] = st_r.in_pix[p];
                end
                else
                begin
                    prod = $signed({1'b0, y}) * $signed(st_r.gain[p]);
                    prod = prod >>> GAIN_FRAC;
                    if (prod < 0)
                    begin
                        y = '0;
                    end
                    else if (prod > $signed({1'b0, {PIX_W{1'b1}}}))
                    begin
                        y = '1;
                    end
                    else
                    begin
                        y = PIX_W'(prod);
                    end
                    if (ctl.prefilter)
                    begin
                        sum_b = {1'b0, cb} + {1'b0, st_r.prev_c[p][PIX_W +: PIX_W]};
                        sum_r = {1'b0, cr} + {1'b0, st_r.prev_c[p][0 +: PIX_W]};
                        cb    = sum_b[PIX_W:1];
                        cr    = sum_r[PIX_W:1];
                    end
                    st_nxt.o_pix[p] = {y, cb, cr};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign mmio_rdata  = st_r.rdata;
    assign mmio_rvalid = st_r.rvalid;
    assign out_valid   = st_r.o_vld;
    assign out_data    = st_r.o_pix;
    assign coef_value  = st_r.cval;
    assign update_armed = st_r.armed;

    for (genvar g = 0; g < PIPES; g++)
    begin : g_out
        assign scaler_on[g]            = st_r.act[g][ENABLE_BIT];
        assign adaptive_vertical_on[g] = st_r.act[g][ADAPT_BIT];
        assign adaptive_strength[g]    = st_r.act[g][STRENGTH_LSB +: 2];
        assign coef_source[g]          = st_r.act[g][SRC_LSB +: 2];
        assign chroma_prefilter_on[g]  = st_r.act[g][PREF_BIT];
    end

endmodule : psf_top

// File: shared/psf_pkg.sv
// Constants, field layouts and types shared by the panel scaler filter block.
// Assumes byte addresses on a 20-bit memory-mapped register port, 32-bit data.
package psf_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int PIPES      = 2;
    localparam int ADDR_W     = 20;
    localparam int COEF_WORDS = 60;
    localparam int PHASES     = 17;
    localparam int TAPS       = 7;
    localparam int CENTER_TAP = 3;
    localparam int PHASE_W    = 5;
    localparam int TAP_W      = 3;
    localparam int HALF_W     = 7;
    localparam int IDX_W      = 6;

    // ------------------------------------------------------------------
    // Register offsets, index 0 is pipe A
    // ------------------------------------------------------------------
    localparam logic [PIPES-1:0][ADDR_W-1:0] CTRL_OFS  = {20'h68880, 20'h68080};
    localparam logic [PIPES-1:0][ADDR_W-1:0] COEF_OFS  = {20'h68900, 20'h68100};
    localparam logic [PIPES-1:0][ADDR_W-1:0] WINSZ_OFS = {20'h68874, 20'h68074};

    // ------------------------------------------------------------------
    // Control word fields and reset values
    // ------------------------------------------------------------------
    localparam int ENABLE_BIT   = 31;
    localparam int ADAPT_BIT    = 27;
    localparam int STRENGTH_LSB = 25;
    localparam int SRC_LSB      = 23;
    localparam int PREF_BIT     = 22;
    localparam logic [31:0] CTRL_MASK  = 32'h8fc0_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Coefficient half-word fields
    // ------------------------------------------------------------------
    localparam int SIGN_BIT = 15;
    localparam int EXP_LSB  = 12;
    localparam int MANT_MSB = 11;
    localparam int MANT_LSB = 3;
    localparam logic [31:0] COEF_MASK  = 32'hbff8_bff8;
    localparam logic [31:0] COEF_RESET = 32'h0000_0000;

    // Decoded coefficients carry this many fraction bits
    localparam int GAIN_FRAC = 12;
    // Centre gains of the built-in sets; plain defaults
    localparam logic signed [15:0] GAIN_MEDIUM = 16'sh1000;
    localparam logic signed [15:0] GAIN_ENH    = 16'sh1400;
    localparam logic signed [15:0] GAIN_SOFT   = 16'sh0c00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SRC_PROGRAMMED, SRC_MEDIUM, SRC_EDGE_ENH, SRC_EDGE_SOFT} psf_src_e;
    typedef enum logic [1:0] {STR_LEAST, STR_MODERATE, STR_RESERVED, STR_MOST} psf_str_e;
    typedef enum logic [1:0] {EXP_TWO_OR_EIGHTH, EXP_ONE, EXP_HALF, EXP_QUARTER} psf_exp_e;

    typedef struct packed {
        logic     enable;
        logic     adaptive;
        psf_str_e strength;
        psf_src_e src;
        logic     prefilter;
    } psf_ctrl_s;

    function automatic psf_ctrl_s psf_unpack(input logic [31:0] w);
        psf_ctrl_s c;
        c.enable    = w[ENABLE_BIT];
        c.adaptive  = w[ADAPT_BIT];
        c.strength  = psf_str_e'(w[STRENGTH_LSB +: 2]);
        c.src       = psf_src_e'(w[SRC_LSB +: 2]);
        c.prefilter = w[PREF_BIT];
        return c;
    endfunction : psf_unpack

endpackage : psf_pkg

// File: shared/psf_coef_if.sv
// Carrier between the scaler top and its coefficient decoder.
// Assumes the decoder answers combinationally.
`timescale 1ns/1ps
interface psf_coef_if;
    logic [15:0]        raw;
    logic               center;
    logic signed [15:0] value;

    modport dec  (input raw, input center, output value);
    modport user (output raw, output center, input value);
endinterface : psf_coef_if

// File: design/psf_coef_decode.sv
// Sign-exponent-mantissa coefficient decoder, no state.
// Assumes reserved bits of the half-word were stored as zero.
`timescale 1ns/1ps
module psf_coef_decode
    import psf_pkg::*;
(
    // Raw half-word in, signed fixed point out
    psf_coef_if.dec cif
);

    logic [8:0]  mant;
    logic [12:0] mag;

    always_comb
    begin
        mant = cif.raw[MANT_MSB:MANT_LSB];
        if (!cif.center)
        begin
            mant[1:0] = 2'h0;
        end
        unique case (psf_exp_e'(cif.raw[EXP_LSB +: 2]))
            EXP_TWO_OR_EIGHTH: mag = cif.center ? {mant, 4'h0} : {4'h0, mant};
            EXP_ONE:           mag = {1'h0, mant, 3'h0};
            EXP_HALF:          mag = {2'h0, mant, 2'h0};
            EXP_QUARTER:       mag = {3'h0, mant, 1'h0};
        endcase
        if (cif.raw[SIGN_BIT])
        begin
            cif.value = -$signed({3'h0, mag});
        end
        else
        begin
            cif.value = $signed({3'h0, mag});
        end
    end

endmodule : psf_coef_decode

// File: dv/psf_top_properties.sv
// Concurrent checks on the panel scaler filter top ports.
// Assumes one clock domain and bind onto every psf_top instance.
`timescale 1ns/1ps
module psf_top_properties
    import psf_pkg::*;
#(
    parameter int PIX_W = 8
)
(
    // Clock and reset
    input wire logic                          clk,
    input wire logic                          rst,
    // Register port
    input wire logic [ADDR_W-1:0]             mmio_addr,
    input wire logic                          mmio_wr,
    input wire logic                          mmio_rd,
    input wire logic [31:0]                   mmio_rdata,
    input wire logic                          mmio_rvalid,
    // Pixel path
    input wire logic [PIPES-1:0]              vblank_start,
    input wire logic [PIPES-1:0]              pix_valid,
    input wire logic [PIPES-1:0][3*PIX_W-1:0] pix_data,
    input wire logic [PIPES-1:0]              out_valid,
    input wire logic [PIPES-1:0][3*PIX_W-1:0] out_data,
    // Active settings
    input wire logic [PIPES-1:0]              scaler_on,
    input wire logic [PIPES-1:0][1:0]         coef_source,
    input wire logic [PIPES-1:0]              chroma_prefilter_on,
    input wire logic [PIPES-1:0]              update_armed
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic arm_a;
    assign arm_a = mmio_wr && (mmio_addr == WINSZ_OFS[0]);

    sequence load_a;
        vblank_start[0] && update_armed[0];
    endsequence

    sequence rd_single;
        mmio_rd ##1 !mmio_rd;
    endsequence

    AST_PIX_LAT_A: assert property (out_valid[0] == $past(pix_valid[0], 2))
        else $error("pipe a output valid not two cycles after input");
    AST_PIX_LAT_B: assert property (out_valid[1] == $past(pix_valid[1], 2))
        else $error("pipe b output valid not two cycles after input");
    AST_BYPASS_A: assert property (pix_valid[0] && !scaler_on[0] && !vblank_start[0]
        |-> ##2 out_data[0] == $past(pix_data[0], 2)) else $error("bypass pixel altered");
    AST_HOLD_A: assert property (!vblank_start[0] |=> $stable(scaler_on[0])
        && $stable(coef_source[0]) && $stable(chroma_prefilter_on[0]))
        else $error("pipe a settings changed outside vertical blank");
    AST_ARM_A: assert property (arm_a |=> update_armed[0])
        else $error("window size write did not arm pipe a");
    AST_DISARM_A: assert property (load_a ##0 !arm_a |=> !update_armed[0])
        else $error("armed flag kept after load");
    AST_ARM_B_QUIET: assert property (arm_a && !update_armed[1] |=> !update_armed[1])
        else $error("pipe a window write armed pipe b");
    AST_HOLD_B: assert property (!vblank_start[1] |=> $stable(scaler_on[1]))
        else $error("pipe b enable changed without its blank");
    AST_RD_ANS: assert property (mmio_rd |=> mmio_rvalid)
        else $error("read not answered next cycle");
    AST_RD_ONCE: assert property (rd_single |=> !mmio_rvalid && mmio_rdata == 32'h0)
        else $error("read answer longer than one cycle");
endmodule : psf_top_properties

bind psf_top psf_top_properties #(.PIX_W(PIX_W)) u_psf_top_properties (.clk, .rst,
    .mmio_addr, .mmio_wr, .mmio_rd, .mmio_rdata, .mmio_rvalid, .vblank_start, .pix_valid,
    .pix_data, .out_valid, .out_data, .scaler_on, .coef_source, .chroma_prefilter_on,
    .update_armed);

// File: dv/psf_pipe_model.sv
// Display pipe model: blank pulses and pixels toward the scaler.
// Assumes the caller steps it one call at a time from the bench.
`timescale 1ns/1ps
module psf_pipe_model
    import psf_pkg::*;
#(
    parameter int PIX_W = 8
)
(
    // Clock
    input wire logic                     clk,
    // Timing and pixels out
    output logic [PIPES-1:0]              vblank_start,
    output logic [PIPES-1:0]              pix_valid,
    output logic [PIPES-1:0][PHASE_W-1:0] pix_phase,
    output logic [PIPES-1:0][3*PIX_W-1:0] pix_data
);
    initial
    begin
        vblank_start = '0;
        pix_valid    = '0;
        pix_phase    = '0;
        pix_data     = '0;
    end

    task automatic vblank(input int p);
        @(posedge clk);
        #1 vblank_start[p] = 1'b1;
        @(posedge clk);
        #1 vblank_start[p] = 1'b0;
    endtask : vblank

    // Idle lines show inverted data so stale values never look valid
    task automatic pixel(input int p, input logic [PHASE_W-1:0] ph, input logic [3*PIX_W-1:0] d);
        @(posedge clk);
        #1 pix_valid[p] = 1'b1;
        pix_phase[p] = ph;
        pix_data[p]  = d;
        @(posedge clk);
        #1 pix_valid[p] = 1'b0;
        pix_phase[p] = ~ph;
        pix_data[p]  = ~d;
    endtask : pixel
endmodule : psf_pipe_model

// File: dv/tb.sv
// Self-checking bench: registers, double buffering, decode, pixel path.
// Assumes psf_pipe_model drives pipe timing one ns after each edge.
`timescale 1ns/1ps
module tb
    import psf_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                          clk        = 1'b0;
    logic                          rst        = 1'b1;
    logic [ADDR_W-1:0]             mmio_addr  = '0;
    logic                          mmio_wr    = 1'b0;
    logic                          mmio_rd    = 1'b0;
    logic [31:0]                   mmio_wdata = '0;
    logic [PIPES-1:0][PHASE_W-1:0] coef_phase = '0;
    logic [PIPES-1:0][TAP_W-1:0]   coef_tap   = '0;
    logic [31:0]                   mmio_rdata;
    logic                          mmio_rvalid;
    logic [PIPES-1:0]              vblank_start, pix_valid, out_valid, scaler_on;
    logic [PIPES-1:0]              adaptive_vertical_on, chroma_prefilter_on, update_armed;
    logic [PIPES-1:0][PHASE_W-1:0] pix_phase;
    logic [PIPES-1:0][23:0]        pix_data, out_data;
    logic [PIPES-1:0][15:0]        coef_value;
    logic [PIPES-1:0][1:0]         adaptive_strength, coef_source;
    int                            fail_count = 0;
    int                            n_compared = 0;

    always #2.5 clk = ~clk;

    psf_top #(.PIX_W(8)) u_psf_top (.clk, .rst, .mmio_addr, .mmio_wr, .mmio_rd, .mmio_wdata,
        .mmio_rdata, .mmio_rvalid, .vblank_start, .pix_valid, .pix_phase, .pix_data,
        .out_valid, .out_data, .coef_phase, .coef_tap, .coef_value, .scaler_on,
        .adaptive_vertical_on, .adaptive_strength, .coef_source, .chroma_prefilter_on,
        .update_armed);
    psf_pipe_model #(.PIX_W(8)) u_psf_pipe_model (.clk, .vblank_start, .pix_valid,
        .pix_phase, .pix_data);

    // ------------------------------------------------------------------
    // Drivers and compare
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 mmio_wr = 1'b1;
        mmio_addr  = a;
        mmio_wdata = d;
        @(posedge clk);
        #1 mmio_wr = 1'b0;
        mmio_wdata = ~d;
    endtask : wr

    // Read answer is fixed at one cycle, so no polling
    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        @(posedge clk);
        #1 mmio_rd = 1'b1;
        mmio_addr = a;
        @(posedge clk);
        #1 mmio_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, mmio_rvalid});
        chk(what, e, mmio_rdata);
    endtask : rd_chk

    task automatic load(input int p, input logic [31:0] v);
        wr(CTRL_OFS[p], v);
        wr(WINSZ_OFS[p], 32'h0);
        chk("armed", 32'(1 << p), {30'h0, update_armed});
        u_psf_pipe_model.vblank(p);
        chk("disarmed", 32'h0, {30'h0, update_armed});
    endtask : load

    task automatic pix_chk(input int p, input logic [4:0] ph, input logic [23:0] d,
                           input logic [23:0] e);
        u_psf_pipe_model.pixel(p, ph, d);
        @(posedge clk);
        #1 chk("out_valid", 32'h1, {31'h0, out_valid[p]});
        chk("out_data", {8'h0, e}, {8'h0, out_data[p]});
    endtask : pix_chk

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        rd_chk("ctrl_a", CTRL_OFS[0], CTRL_RESET);
        rd_chk("coef_a0", COEF_OFS[0], COEF_RESET);
        chk("active", 32'h0, {26'h0, scaler_on, coef_source[0], update_armed});
        wr(CTRL_OFS[1], 32'hffff_ffff);
        rd_chk("ctrl_b mask", CTRL_OFS[1], CTRL_MASK);
        wr(COEF_OFS[1] + 20'd236, 32'h0000_8a50);
        rd_chk("coef_b59", COEF_OFS[1] + 20'd236, 32'h0000_8a50);
        rd_chk("coef_a59", COEF_OFS[0] + 20'd236, COEF_RESET);
        rd_chk("past end", COEF_OFS[0] + 20'd240, 32'h0);
        rd_chk("win size", WINSZ_OFS[0], 32'h0);
        wr(CTRL_OFS[1], 32'h0);
        pix_chk(0, 5'd5, 24'h123456, 24'h123456);
        $display("test regs and bypass done");
    endtask : t_regs

    task automatic t_modes;
        logic [1:0]  str [4] = '{2'd0, 2'd1, 2'd3, 2'd1};
        logic [1:0]  prev    = 2'd0;
        logic [31:0] v;
        for (int i = 0; i < 4; i++)
        begin
            v = {1'b1, 3'b0, i[0], str[i], i[1:0], i[1], 22'h0};
            wr(CTRL_OFS[0], v);
            u_psf_pipe_model.vblank(0);
            chk("held source", {30'h0, prev}, {30'h0, coef_source[0]});
            load(0, v);
            chk("enable", 32'h1, {31'h0, scaler_on[0]});
            chk("adaptive", {31'h0, v[27]}, {31'h0, adaptive_vertical_on[0]});
            chk("strength", {30'h0, v[26:25]}, {30'h0, adaptive_strength[0]});
            chk("source", {30'h0, v[24:23]}, {30'h0, coef_source[0]});
            chk("prefilter", {31'h0, v[22]}, {31'h0, chroma_prefilter_on[0]});
            chk("pipe b off", 32'h0, {31'h0, scaler_on[1]});
            prev = v[24:23];
        end
        $display("test modes done");
    endtask : t_modes

    task automatic t_coef;
        logic [23:0] tbl [5] = '{{5'd0, 3'd3, 16'h0800}, {5'd0, 3'd2, 16'hfe00},
            {5'd0, 3'd4, 16'h01fc}, {5'd1, 3'd3, 16'h1000}, {5'd1, 3'd4, 16'h0080}};
        // gains above one only at centre
        // one luma array serves RGB data too
        wr(COEF_OFS[0] + 20'd4, 32'h1800_a400);
        wr(COEF_OFS[0] + 20'd8, 32'h0000_0ff8);
        wr(COEF_OFS[0] + 20'd20, 32'h3200_0800);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            #1 coef_phase[0] = tbl[i][23:19];
            coef_tap[0] = tbl[i][18:16];
            @(posedge clk);
            #1 chk("coef", {16'h0, tbl[i][15:0]}, {16'h0, coef_value[0]});
        end
        load(0, 32'h8000_0000);
        pix_chk(0, 5'd0, 24'h801122, 24'h401122);
        pix_chk(0, 5'd1, 24'hc81122, 24'hc81122);
        load(0, 32'h8100_0000);
        pix_chk(0, 5'd0, 24'hf01122, 24'hff1122);
        load(0, 32'h8180_0000);
        pix_chk(0, 5'd0, 24'h801122, 24'h601122);
        load(0, 32'h80c0_0000);
        u_psf_pipe_model.pixel(0, 5'd0, 24'h101020);
        pix_chk(0, 5'd0, 24'h103060, 24'h102040);
        // Negative centre gain clamps luma at zero
        wr(COEF_OFS[1] + 20'd4, 32'h9800_0000);
        load(1, 32'h8000_0000);
        chk("both on", 32'h3, {30'h0, scaler_on});
        pix_chk(1, 5'd0, 24'h805566, 24'h005566);
        $display("test coefficients and pixels done");
    endtask : t_coef

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        t_regs();
        t_modes();
        t_coef();
        end_of_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
endmodule : tb
